// >>> design/drive_di_cfg.svh
// Constants of the digital input function decoder.
// Assumes inclusion by bare name from the package and design modules.
`ifndef DRIVE_DI_CFG_SVH
`define DRIVE_DI_CFG_SVH

// Terminal function codes
`define FN_MREF1        6'h0C
`define FN_MREF2        6'h0D
`define FN_MREF3        6'h0E
`define FN_MREF4        6'h0F
`define FN_ACCDEC1      6'h10
`define FN_ACCDEC2      6'h11
`define FN_AUX_PRESET   6'h28
`define FN_MOTOR_SEL    6'h29
`define FN_PID_GAIN     6'h2B
`define FN_USER_FAULT1  6'h2C
`define FN_USER_FAULT2  6'h2D
`define FN_MODE_SWAP    6'h2E
`define FN_ESTOP        6'h2F
`define FN_STOP_DEC4    6'h30
`define FN_DECEL_DCB    6'h31
`define FN_RUNTIME_CLR  6'h32
`define FN_LINE_SWAP    6'h33

// Fault codes, selector values, modes
`define USER_FAULT_ONE_CODE 8'h1B
`define USER_FAULT_TWO_CODE 8'h1C
`define PID_SW_BY_TERMINAL  4'h1
`define CMD_TWO_LINE_1      2'h0
`define CMD_THREE_LINE_1    2'h2
`define ACCDEC_TIME_4       2'h3

// Timing and scaling
`define CLK_PERIOD_NS   5
`define FILTER_UNIT_NS  1000000
`define FILTER_MAX_MS   10'h3E8
`define FILTER_DEF_MS   10'h00A
`define PCT_FULL_SCALE  32'h0000_2710

`endif

// >>> design/drive_di_pkg.sv
// Types shared by the digital input function decoder.
// Assumes drive_di_cfg.svh is on the include path.
`include "drive_di_cfg.svh"

package drive_di_pkg;
    typedef logic [5:0] func_code_t;
    typedef logic [1:0] cmd_mode_t;
    typedef enum logic [1:0] {
        DCB_IDLE,
        DCB_DECEL,
        DCB_BRAKE
    } dcb_state_e;
endpackage : drive_di_pkg

// >>> design/ref_table.sv
// Sixteen-entry multi-reference store with registered read data.
// Assumes one writer from the control core and a single clock.
`timescale 1ns/1ps

module ref_table #(
    parameter int DEPTH = 16,
    parameter int W     = 16,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic          clk_sys_in,
    input  wire logic          rst_n_in,
    // Write port
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [W-1:0]  wr_data_in,
    // Read port
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [W-1:0]  rd_data_out
);
    logic [W-1:0] mem_r [DEPTH];

    // Cleared at reset so an unwritten reference selects zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem_r[rd_addr_in];
        end
    end
endmodule : ref_table

// >>> design/drive_di_functions.sv
// Digital input terminal filter and function decoder of the drive.
// Assumes terminal levels synchronous to clk_sys_in, active high = ON.
`timescale 1ns/1ps
`include "drive_di_cfg.svh"

module drive_di_functions
    import drive_di_pkg::*;
#(
    parameter int N_DI          = 8,
    parameter int CNT_W         = 28,
    parameter int REF_W         = 16,
    parameter int FREQ_W        = 16,
    parameter int CYCLES_PER_MS = `FILTER_UNIT_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    // Terminals and their function assignment
    input  wire logic [N_DI-1:0]     di_level_in,
    input  wire logic [N_DI*6-1:0]   di_function_in,
    input  wire logic [9:0]          input_filter_time_setting_in,
    // Settings
    input  wire logic [3:0]          pid_gain_switch_source_in,
    input  wire logic                base_control_mode_setting_in,
    input  wire cmd_mode_t           terminal_command_mode_setting_in,
    input  wire logic [FREQ_W-1:0]   preset_frequency_setting_in,
    input  wire logic [FREQ_W-1:0]   maximum_frequency_setting_in,
    // Control core status
    input  wire logic [FREQ_W-1:0]   aux_freq_in,
    input  wire logic [FREQ_W-1:0]   output_frequency_in,
    input  wire logic [FREQ_W-1:0]   dcb_start_freq_in,
    input  wire logic [15:0]         current_upper_limit_in,
    input  wire logic                fault_ack_in,
    // Reference table write
    input  wire logic                ref_wr_en_in,
    input  wire logic [3:0]          ref_wr_addr_in,
    input  wire logic [REF_W-1:0]    ref_wr_data_in,
    // Decoded selections
    output logic [N_DI-1:0]          di_filtered_out,
    output logic                     aux_preset_sel_out,
    output logic [FREQ_W-1:0]        aux_freq_out,
    output logic                     motor_set_sel_out,
    output logic                     pid_gain_set_out,
    output logic                     user_fault_out,
    output logic [7:0]               fault_code_out,
    output logic                     control_mode_out,
    output logic                     estop_out,
    output logic [15:0]              estop_current_out,
    output logic                     forced_stop_out,
    output logic [1:0]               accdec_sel_out,
    output logic                     decel_dcb_out,
    output logic                     dc_brake_out,
    output logic                     run_time_clear_out,
    output cmd_mode_t                command_mode_out,
    output logic [3:0]               multi_ref_idx_out,
    output logic [REF_W-1:0]         multi_ref_pct_out,
    output logic [FREQ_W-1:0]        multi_ref_freq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // ==================================================================
    // Input filter
    // ==================================================================
    logic [9:0]       filt_ms;
    logic [CNT_W-1:0] filt_lim_r;
    logic [N_DI-1:0]  filt_r;
    logic [CNT_W-1:0] filt_cnt_r [N_DI];

    // Out-of-range setting clamps to the longest interval
    assign filt_ms = (input_filter_time_setting_in > `FILTER_MAX_MS) ?
                     `FILTER_MAX_MS : input_filter_time_setting_in;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filt_lim_r <= CNT_W'(`FILTER_DEF_MS * CYCLES_PER_MS);
        end else begin
            filt_lim_r <= CNT_W'(filt_ms * CYCLES_PER_MS);
        end
    end

    // Any bounce restarts the count, so only a steady level gets through
    for (genvar g = 0; g < N_DI; g++) begin : g_filt
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                filt_r[g]     <= 1'b0;
                filt_cnt_r[g] <= '0;
            end else if (di_level_in[g] == filt_r[g]) begin
                filt_cnt_r[g] <= '0;
            end else if (filt_cnt_r[g] >= filt_lim_r) begin
                filt_r[g]     <= di_level_in[g];
                filt_cnt_r[g] <= '0;
            end else begin
                filt_cnt_r[g] <= filt_cnt_r[g] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            di_filtered_out <= '0;
        end else begin
            di_filtered_out <= filt_r;
        end
    end

    // ==================================================================
    // Function decode
    // ==================================================================
    logic [63:0] act;

    // Several terminals on one function act as a wired OR
    always_comb begin
        act = '0;
        for (int i = 0; i < N_DI; i++) begin
            if (filt_r[i]) begin
                act[func_code_t'(di_function_in[i*6 +: 6])] = 1'b1;
            end
        end
    end

    // ==================================================================
    // Frequency source, motor, gains, mode
    // ==================================================================
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_preset_sel_out <= 1'b0;
            aux_freq_out       <= '0;
        end else begin
            aux_preset_sel_out <= act[`FN_AUX_PRESET];
            aux_freq_out       <= act[`FN_AUX_PRESET] ?
                                  preset_frequency_setting_in : aux_freq_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            motor_set_sel_out <= 1'b0;
            pid_gain_set_out  <= 1'b0;
            control_mode_out  <= 1'b0;
        end else begin
            motor_set_sel_out <= act[`FN_MOTOR_SEL];
            pid_gain_set_out  <= (pid_gain_switch_source_in == `PID_SW_BY_TERMINAL)
                                 && act[`FN_PID_GAIN];
            control_mode_out  <= base_control_mode_setting_in
                                 ^ act[`FN_MODE_SWAP];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            command_mode_out <= `CMD_TWO_LINE_1;
        end else if (terminal_command_mode_setting_in == `CMD_TWO_LINE_1
                     && act[`FN_LINE_SWAP]) begin
            command_mode_out <= `CMD_THREE_LINE_1;
        end else begin
            command_mode_out <= terminal_command_mode_setting_in;
        end
    end

    // ==================================================================
    // User faults
    // ==================================================================
    // Sticky until acknowledged; a fault present at the ack stays set
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            user_fault_out <= 1'b0;
            fault_code_out <= '0;
        end else if (act[`FN_USER_FAULT1]) begin
            user_fault_out <= 1'b1;
            fault_code_out <= `USER_FAULT_ONE_CODE;
        end else if (act[`FN_USER_FAULT2]) begin
            user_fault_out <= 1'b1;
            fault_code_out <= `USER_FAULT_TWO_CODE;
        end else if (fault_ack_in) begin
            user_fault_out <= 1'b0;
            fault_code_out <= '0;
        end
    end

    // ==================================================================
    // Stops and speed selectors
    // ==================================================================
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            estop_out         <= 1'b0;
            estop_current_out <= '0;
        end else begin
            estop_out         <= act[`FN_ESTOP];
            estop_current_out <= act[`FN_ESTOP] ? current_upper_limit_in : '0;
        end
    end

    // Forced stop overrides the terminal selection of time pair
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            forced_stop_out <= 1'b0;
            accdec_sel_out  <= '0;
        end else begin
            forced_stop_out <= act[`FN_STOP_DEC4];
            accdec_sel_out  <= act[`FN_STOP_DEC4] ? `ACCDEC_TIME_4 :
                               {act[`FN_ACCDEC2], act[`FN_ACCDEC1]};
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_time_clear_out <= 1'b0;
        end else begin
            run_time_clear_out <= act[`FN_RUNTIME_CLR] && !run_time_clear_out;
        end
    end

    // ==================================================================
    // Deceleration DC braking
    // ==================================================================
    dcb_state_e dcb_r;
    dcb_state_e dcb_nxt;

    always_comb begin
        dcb_nxt = dcb_r;
        unique case (dcb_r)
            DCB_IDLE: begin
                if (act[`FN_DECEL_DCB]) dcb_nxt = DCB_DECEL;
            end
            DCB_DECEL: begin
                if (!act[`FN_DECEL_DCB]) dcb_nxt = DCB_IDLE;
                else if (output_frequency_in <= dcb_start_freq_in) dcb_nxt = DCB_BRAKE;
            end
            DCB_BRAKE: begin
                if (!act[`FN_DECEL_DCB]) dcb_nxt = DCB_IDLE;
            end
            default: dcb_nxt = DCB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dcb_r         <= DCB_IDLE;
            decel_dcb_out <= 1'b0;
            dc_brake_out  <= 1'b0;
        end else begin
            dcb_r         <= dcb_nxt;
            decel_dcb_out <= (dcb_nxt == DCB_DECEL);
            dc_brake_out  <= (dcb_nxt == DCB_BRAKE);
        end
    end

    // ==================================================================
    // Multi-reference
    // ==================================================================
    logic [3:0]       mref_idx;
    logic [REF_W-1:0] mref_rd;
    logic [31:0]      mref_prod;

    assign mref_idx = {act[`FN_MREF4], act[`FN_MREF3],
                       act[`FN_MREF2], act[`FN_MREF1]};

    ref_table #(
        .DEPTH (16),
        .W     (REF_W),
        .AW    (4)
    ) u_ref_table (
        .clk_sys_in  (clk_sys_in),
        .rst_n_in    (rst_n_in),
        .wr_en_in    (ref_wr_en_in),
        .wr_addr_in  (ref_wr_addr_in),
        .wr_data_in  (ref_wr_data_in),
        .rd_addr_in  (mref_idx),
        .rd_data_out (mref_rd)
    );

    // References are in hundredths of a percent; above full scale is not clamped
    assign mref_prod = 32'(mref_rd) * 32'(maximum_frequency_setting_in);

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            multi_ref_idx_out  <= '0;
            multi_ref_pct_out  <= '0;
            multi_ref_freq_out <= '0;
        end else begin
            multi_ref_idx_out  <= mref_idx;
            multi_ref_pct_out  <= mref_rd;
            multi_ref_freq_out <= FREQ_W'(mref_prod / `PCT_FULL_SCALE);
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    chk_aux_preset: assert property (
        1 |=> aux_freq_out == ($past(act[`FN_AUX_PRESET]) ?
              $past(preset_frequency_setting_in) : $past(aux_freq_in)))
        else $error("aux source not substituted");

    chk_motor_set: assert property (
        act[`FN_MOTOR_SEL] != motor_set_sel_out |=> $changed(motor_set_sel_out))
        else $error("motor set not following selector");

    chk_pid_gain: assert property (
        pid_gain_switch_source_in != `PID_SW_BY_TERMINAL |=> !pid_gain_set_out)
        else $error("gain switched without terminal source");

    chk_user_fault: assert property (
        act[`FN_USER_FAULT2] && !act[`FN_USER_FAULT1]
        |=> user_fault_out && fault_code_out == `USER_FAULT_TWO_CODE)
        else $error("user fault two not raised");

    chk_mode_swap: assert property (
        act[`FN_MODE_SWAP] |=> control_mode_out != $past(base_control_mode_setting_in))
        else $error("control mode not swapped");

    chk_estop_hold: assert property (
        act[`FN_ESTOP] |=> estop_out && estop_current_out == $past(current_upper_limit_in))
        else $error("emergency stop current wrong");

    chk_stop_dec4: assert property (
        act[`FN_STOP_DEC4] |=> forced_stop_out && accdec_sel_out == `ACCDEC_TIME_4)
        else $error("forced stop not on time 4");

    chk_dcb_order: assert property (
        $rose(dc_brake_out) |-> $past(decel_dcb_out))
        else $error("braking without prior deceleration");

    chk_clear_pulse: assert property (
        act[`FN_RUNTIME_CLR] [*2] |=> run_time_clear_out != $past(run_time_clear_out))
        else $error("run time clear not pulsing");

    chk_line_swap: assert property (
        act[`FN_LINE_SWAP] && terminal_command_mode_setting_in == `CMD_TWO_LINE_1
        |=> command_mode_out == `CMD_THREE_LINE_1)
        else $error("three-line mode not entered");

    chk_mref_path: assert property (
        $stable(mref_idx) [*3] ##0 !$past(ref_wr_en_in, 2) && !$past(ref_wr_en_in)
        |-> multi_ref_pct_out == u_ref_table.mem_r[multi_ref_idx_out])
        else $error("multi reference value mismatch");

    chk_filter_hold: assert property (
        $changed(filt_r[0]) |-> $past(filt_cnt_r[0]) >= $past(filt_lim_r))
        else $error("level accepted before interval elapsed");
endmodule : drive_di_functions

// >>> dv/terminal_switches.sv
// Model of the switches wired to the drive's digital input terminals.
// Assumes the bench calls its tasks; levels change just after a rising edge.
`timescale 1ns/1ps

module terminal_switches (
    // Clock
    input  wire logic       clk_in,
    // Terminal levels, 1 = contact closed
    output logic      [7:0] level_out
);
    initial level_out = 8'h00;

    // ==================================================
    // Stimulus tasks
    task automatic set_lv(input logic [7:0] v);
        @(posedge clk_in);
        level_out <= v;
    endtask : set_lv

    // Contact bounce: masked terminals flip for n cycles, then return
    task automatic glitch(input logic [7:0] m, input int n);
        @(posedge clk_in);
        level_out <= level_out ^ m;
        repeat (n) @(posedge clk_in);
        level_out <= level_out ^ m;
    endtask : glitch
endmodule : terminal_switches

// >>> dv/drive_di_functions_tb_top.sv
// Self-checking bench of the digital input function decoder.
// Assumes the design files and drive_di_cfg.svh are on the include path.
`timescale 1ns/1ps
`include "drive_di_cfg.svh"

module drive_di_functions_tb_top;
    import drive_di_pkg::*;
    // Run is about 340 cycles; generous ceiling
    localparam int LIMIT = 20000;

    logic        clk_sys_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic [7:0]  di_lv;
    logic [47:0] fn         = 48'h0;
    logic [9:0]  filt_ms    = 10'h000;
    logic [3:0]  pid_src    = 4'h1;
    logic        base_mode  = 1'b0;
    cmd_mode_t   cmd_set    = 2'h0;
    logic [15:0] preset     = 16'h1234;
    logic [15:0] fmax       = 16'h1F40;
    logic [15:0] aux        = 16'h0ABC;
    logic [15:0] out_f      = 16'h03E8;
    logic [15:0] dcb_f      = 16'h00C8;
    logic [15:0] cur_lim    = 16'h0321;
    logic        ack        = 1'b0;
    logic        wr_en      = 1'b0;
    logic [3:0]  wr_a       = 4'h0;
    logic [15:0] wr_d       = 16'h0000;
    logic [7:0]  filt_o;
    logic        aux_sel, motor, pidg, ufault, cmode, estop, fstop, dec, brake, rclr;
    logic [7:0]  fcode;
    logic [15:0] aux_o, est_cur, pct, freq;
    logic [1:0]  accdec;
    cmd_mode_t   cmd_o;
    logic [3:0]  idx;
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    terminal_switches u_sw (.clk_in(clk_sys_in), .level_out(di_lv));

    drive_di_functions #(.CYCLES_PER_MS(4)) u_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .di_level_in(di_lv),
        .di_function_in(fn), .input_filter_time_setting_in(filt_ms),
        .pid_gain_switch_source_in(pid_src), .base_control_mode_setting_in(base_mode),
        .terminal_command_mode_setting_in(cmd_set), .preset_frequency_setting_in(preset),
        .maximum_frequency_setting_in(fmax), .aux_freq_in(aux), .output_frequency_in(out_f),
        .dcb_start_freq_in(dcb_f), .current_upper_limit_in(cur_lim), .fault_ack_in(ack),
        .ref_wr_en_in(wr_en), .ref_wr_addr_in(wr_a), .ref_wr_data_in(wr_d),
        .di_filtered_out(filt_o), .aux_preset_sel_out(aux_sel), .aux_freq_out(aux_o),
        .motor_set_sel_out(motor), .pid_gain_set_out(pidg), .user_fault_out(ufault),
        .fault_code_out(fcode), .control_mode_out(cmode), .estop_out(estop),
        .estop_current_out(est_cur), .forced_stop_out(fstop), .accdec_sel_out(accdec),
        .decel_dcb_out(dec), .dc_brake_out(brake), .run_time_clear_out(rclr),
        .command_mode_out(cmd_o), .multi_ref_idx_out(idx), .multi_ref_pct_out(pct),
        .multi_ref_freq_out(freq)
    );

    // ==================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic set_fn(input logic [47:0] v);
        @(posedge clk_sys_in);
        fn <= v;
    endtask : set_fn

    task automatic pulse_ack;
        @(posedge clk_sys_in);
        ack <= 1'b1;
        @(posedge clk_sys_in);
        ack <= 1'b0;
    endtask : pulse_ack

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // Hang guard
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            conclude();
        end
    end

    // ==================================================
    // Test sequence
    initial begin
        logic [15:0] v;
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        // Level functions, all terminals on, then off
        set_fn({`FN_RUNTIME_CLR, `FN_LINE_SWAP, `FN_STOP_DEC4, `FN_ESTOP,
                `FN_MODE_SWAP, `FN_PID_GAIN, `FN_MOTOR_SEL, `FN_AUX_PRESET});
        u_sw.set_lv(8'hFF);
        step(5);
        chk(aux_o, preset);
        chk(16'(motor), 16'h0001);
        chk(16'(pidg), 16'h0001);
        chk(16'(cmode), 16'h0001);
        chk(16'(estop), 16'h0001);
        chk(est_cur, cur_lim);
        chk(16'(fstop), 16'h0001);
        chk(16'(accdec), 16'h0003);
        chk(16'(cmd_o), 16'(`CMD_THREE_LINE_1));
        v = 16'(rclr);
        step(1);
        chk(v | 16'(rclr), 16'h0001);
        // Swap only applies from two-line mode 1
        @(posedge clk_sys_in);
        cmd_set <= 2'h1;
        step(3);
        chk(16'(cmd_o), 16'h0001);
        u_sw.set_lv(8'h00);
        step(5);
        chk(aux_o, aux);
        chk(16'(motor), 16'h0000);
        chk(16'(pidg), 16'h0000);
        chk(16'(cmode), 16'h0000);
        chk(16'(estop), 16'h0000);
        chk(16'(fstop), 16'h0000);
        chk(16'(rclr), 16'h0000);
        // No terminal gain source, other base mode, new source values
        @(posedge clk_sys_in);
        pid_src   <= 4'h0;
        base_mode <= 1'b1;
        preset    <= 16'h2345;
        aux       <= 16'h0DEF;
        cur_lim   <= 16'h0456;
        u_sw.set_lv(8'hFF);
        step(5);
        chk(aux_o, 16'h2345);
        chk(16'(pidg), 16'h0000);
        chk(16'(cmode), 16'h0000);
        chk(est_cur, 16'h0456);
        u_sw.set_lv(8'h00);
        step(5);
        chk(aux_o, 16'h0DEF);
        chk(16'(cmode), 16'h0001);
        chk(est_cur, 16'h0000);
        // Multi-reference and acc/dec selection over all combinations
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_sys_in);
            wr_en <= 1'b1;
            wr_a  <= 4'(k);
            wr_d  <= 16'(k * 625);
            @(posedge clk_sys_in);
            wr_en <= 1'b0;
        end
        set_fn({12'h000, `FN_ACCDEC2, `FN_ACCDEC1, `FN_MREF4, `FN_MREF3, `FN_MREF2, `FN_MREF1});
        for (int k = 0; k < 16; k++) begin
            u_sw.set_lv({2'b00, 2'(k), 4'(k)});
            step(6);
            chk(16'(idx), 16'(k));
            chk(pct, 16'(k * 625));
            chk(freq, 16'((k * 625 * 8000) / 10000));
            chk(16'(accdec), 16'(k % 4));
        end
        // User faults: sticky, 44 has priority
        set_fn({36'h0, `FN_USER_FAULT2, `FN_USER_FAULT1});
        u_sw.set_lv(8'h02);
        step(5);
        chk(16'(fcode), 16'(`USER_FAULT_TWO_CODE));
        u_sw.set_lv(8'h00);
        step(5);
        chk(16'(ufault), 16'h0001);
        pulse_ack();
        step(3);
        chk(16'(fcode), 16'h0000);
        u_sw.set_lv(8'h03);
        step(5);
        chk(16'(fcode), 16'(`USER_FAULT_ONE_CODE));
        // Ack while a fault input is still on must not clear it
        pulse_ack();
        step(2);
        chk(16'(ufault), 16'h0001);
        u_sw.set_lv(8'h00);
        pulse_ack();
        step(3);
        chk(16'(ufault), 16'h0000);
        // Decelerate, then DC brake below the start frequency
        set_fn({42'h0, `FN_DECEL_DCB});
        u_sw.set_lv(8'h01);
        step(5);
        chk({15'h0, dec}, 16'h0001);
        chk(16'(brake), 16'h0000);
        @(posedge clk_sys_in);
        out_f <= 16'h0096;
        step(4);
        chk(16'(brake), 16'h0001);
        u_sw.set_lv(8'h00);
        step(5);
        chk(16'(brake | dec), 16'h0000);
        // Filter at 10 ms = 40 cycles: bounce ignored, steady level taken late
        set_fn({42'h0, `FN_AUX_PRESET});
        @(posedge clk_sys_in);
        filt_ms <= `FILTER_DEF_MS;
        step(3);
        u_sw.glitch(8'h01, 20);
        step(25);
        chk(16'(filt_o), 16'h0000);
        chk(16'(aux_sel), 16'h0000);
        u_sw.set_lv(8'h01);
        step(39);
        chk(16'(filt_o), 16'h0000);
        step(6);
        chk(16'(filt_o), 16'h0001);
        chk(16'(aux_sel), 16'h0001);
        conclude();
    end
endmodule : drive_di_functions_tb_top
